// [verilog/gate_driver_regs.svh]
// Command field layout, reset values and timing constants of the gate driver.
`ifndef GATE_DRIVER_REGS_SVH
`define GATE_DRIVER_REGS_SVH

`define CMD_WIDTH 8
`define CMD_ON_LSB 0
`define CMD_ON_WIDTH 4
`define CMD_DEGLITCH_LSB 4
`define CMD_DEGLITCH_WIDTH 3
`define CMD_SLEEP_BIT 7
`define CMD_RESET_VALUE 8'h00
`define FAULT_WORD_RESET 8'h00
`define CHANNELS 4
`define CODE_WIDTH 2
`define CLK_MHZ 25
`define DEGLITCH_BASE_US 10
`define RETRY_OFF_US 10000
`define TIMER_WIDTH 16
`define RETRY_WIDTH 20

`endif

// [verilog/gate_driver_pkg.sv]
// Types shared by the gate driver control logic.
package gate_driver_pkg;

  // Declaration order gives the codes 00, 01, 10 and 11.
  typedef enum logic [1:0] {
    FAULT_NONE,
    FAULT_OPEN_LOAD,
    FAULT_OVER_CURRENT,
    FAULT_SHORT_GROUND
  } fault_code_t;

  typedef enum logic [1:0] {
    CH_OFF,
    CH_ON,
    CH_LATCHED,
    CH_RETRY_WAIT
  } channel_state_t;

endpackage

// [verilog/bit_sync.sv]
// Two-flop synchroniser for a group of independent level signals.
module bit_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] q_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_r <= '0;
      q_r <= '0;
    end else begin
      meta_r <= d;
      q_r <= meta_r;
    end
  end

  assign q = q_r;

endmodule

// [verilog/channel_guard.sv]
// One gate channel: on/off state, fault deglitch, latch-off and auto-retry.
`include "gate_driver_regs.svh"
module channel_guard (
  input wire logic clk,
  input wire logic rst,
  input wire logic on_request,
  input wire logic enable,
  input wire logic retry_select,
  input wire logic [`TIMER_WIDTH-1:0] deglitch_limit,
  input wire logic [`RETRY_WIDTH-1:0] retry_off_cycles,
  input wire logic open_det,
  input wire logic overcurrent_det,
  input wire logic short_det,
  input wire logic clear_code,
  output logic gate,
  output gate_driver_pkg::fault_code_t code,
  output logic fault_event,
  output logic held_off
);

  gate_driver_pkg::channel_state_t st_r, st_nxt;
  gate_driver_pkg::fault_code_t cand, cand_r, code_r, code_nxt;
  logic [`TIMER_WIDTH-1:0] cnt_r, cnt_nxt;
  logic [`RETRY_WIDTH-1:0] wait_r, wait_nxt;
  logic reported_r, reported_nxt;
  logic gate_r, gate_nxt;
  logic match, hit, hard;

  always_comb begin
    cand = gate_driver_pkg::FAULT_NONE;
    if (gate_r) begin
      if (short_det) begin
        cand = gate_driver_pkg::FAULT_SHORT_GROUND;
      end else if (overcurrent_det) begin
        cand = gate_driver_pkg::FAULT_OVER_CURRENT;
      end
    end else if (open_det) begin
      cand = gate_driver_pkg::FAULT_OPEN_LOAD;
    end
    match = (cand != gate_driver_pkg::FAULT_NONE) && (cand == cand_r);
    // A fault counts only after it stood unchanged for the whole interval.
    hit = match && !reported_r &&
          (({1'b0, cnt_r} + 17'h00001) >= {1'b0, deglitch_limit});
    hard = (cand == gate_driver_pkg::FAULT_OVER_CURRENT) ||
           (cand == gate_driver_pkg::FAULT_SHORT_GROUND);
    cnt_nxt = '0;
    reported_nxt = 1'b0;
    if (match) begin
      reported_nxt = reported_r | hit;
      cnt_nxt = (reported_r || hit) ? cnt_r : cnt_r + 16'h0001;
    end
    // A new fault wins over a clear in the same cycle.
    code_nxt = clear_code ? gate_driver_pkg::FAULT_NONE : code_r;
    if (hit) begin
      code_nxt = cand;
    end
    st_nxt = st_r;
    wait_nxt = wait_r;
    case (st_r)
      gate_driver_pkg::CH_OFF: begin
        if (enable && on_request) begin
          st_nxt = gate_driver_pkg::CH_ON;
        end
      end
      gate_driver_pkg::CH_ON: begin
        if (!(enable && on_request)) begin
          st_nxt = gate_driver_pkg::CH_OFF;
        end else if (hit && hard) begin
          if (retry_select) begin
            st_nxt = gate_driver_pkg::CH_RETRY_WAIT;
            wait_nxt = retry_off_cycles;
          end else begin
            st_nxt = gate_driver_pkg::CH_LATCHED;
          end
        end
      end
      gate_driver_pkg::CH_LATCHED: begin
        // The latch holds until the channel is commanded off.
        if (!on_request) begin
          st_nxt = gate_driver_pkg::CH_OFF;
        end
      end
      gate_driver_pkg::CH_RETRY_WAIT: begin
        // Long off time, then one more try: the low duty cycle retry.
        if (!on_request || wait_r == 20'h00000) begin
          st_nxt = gate_driver_pkg::CH_OFF;
        end else begin
          wait_nxt = wait_r - 20'h00001;
        end
      end
      default: begin
        st_nxt = gate_driver_pkg::CH_OFF;
      end
    endcase
    gate_nxt = (st_nxt == gate_driver_pkg::CH_ON);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= gate_driver_pkg::CH_OFF;
      cand_r <= gate_driver_pkg::FAULT_NONE;
      code_r <= gate_driver_pkg::FAULT_NONE;
      cnt_r <= '0;
      wait_r <= '0;
      reported_r <= 1'b0;
      gate_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cand_r <= cand;
      code_r <= code_nxt;
      cnt_r <= cnt_nxt;
      wait_r <= wait_nxt;
      reported_r <= reported_nxt;
      gate_r <= gate_nxt;
    end
  end

  assign gate = gate_r;
  assign code = code_r;
  assign fault_event = hit;
  assign held_off = (st_r == gate_driver_pkg::CH_LATCHED) ||
                    (st_r == gate_driver_pkg::CH_RETRY_WAIT);

endmodule

// [verilog/quad_gate_driver_serial_fault_ctrl.sv]
// Serial link, command register and fault reporting of the four-channel gate driver.
`include "gate_driver_regs.svh"
module quad_gate_driver_serial_fault_ctrl #(
  parameter int DEGLITCH_BASE_CYCLES = `DEGLITCH_BASE_US * `CLK_MHZ,
  parameter int RETRY_OFF_CYCLES = `RETRY_OFF_US * `CLK_MHZ
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdi,
  output logic sdo,
  output logic sdo_oe,
  input wire logic retry_select,
  input wire logic [`CHANNELS-1:0] parallel_gate_inputs,
  input wire logic [`CHANNELS-1:0] fet_source_open,
  input wire logic [`CHANNELS-1:0] fet_source_overcurrent,
  input wire logic [`CHANNELS-1:0] fet_source_short,
  input wire logic supply_overvoltage,
  output logic [`CHANNELS-1:0] gate_drive_outputs,
  input wire logic fault_interrupt_n_in,
  output logic fault_interrupt_n_out,
  output logic fault_interrupt_n_oe,
  output logic sleep_state
);

  localparam int FRAME_BITS = `CMD_WIDTH;

  // Link side, on the serial clock. Frame-scoped state is cleared by chip
  // select itself, since the serial clock stands still between frames.
  logic link_rst;
  logic [FRAME_BITS:0] ext_r, ext_nxt;
  logic byte_tog_r, byte_tog_nxt;
  logic [2:0] bit_cnt_r, bit_cnt_nxt;
  logic started_r, started_nxt;
  logic sdo_r, sdo_nxt;
  logic sdo_oe_r, sdo_oe_nxt;

  // Core side.
  logic cs_s, cs_q_r, cs_rise, cs_fall;
  logic tog_s, tog_q_r, tog_change;
  logic pend_r, pend_nxt;
  logic [FRAME_BITS-1:0] cmd_r, cmd_nxt;
  logic [FRAME_BITS-1:0] fault_word_r, fault_word_nxt;
  logic flt_r, flt_nxt;
  logic flt_out_r;
  logic sleep_r;
  logic retry_s, ovlo_s;
  logic [`CHANNELS-1:0] par_s, open_s, oc_s, short_s;
  logic [`CHANNELS-1:0] on_request, gate_w, event_w, held_w;
  gate_driver_pkg::fault_code_t code_w [`CHANNELS];
  logic [`TIMER_WIDTH-1:0] deglitch_limit;
  logic [`CMD_DEGLITCH_WIDTH-1:0] deglitch_sel;
  logic enable;

  assign link_rst = rst | cs_n;

  always_comb begin
    // Fault data enters on the first rising edge; input bits trail it by
    // one frame length, which is what lets devices share one chain.
    if (started_r) begin
      ext_nxt = {ext_r[FRAME_BITS-1:0], sdi};
    end else begin
      ext_nxt = {fault_word_r, sdi};
    end
    started_nxt = 1'b1;
    bit_cnt_nxt = bit_cnt_r + 3'h1;
    byte_tog_nxt = (bit_cnt_r == 3'h7) ? !byte_tog_r : byte_tog_r;
    sdo_nxt = ext_r[FRAME_BITS];
    sdo_oe_nxt = 1'b1;
  end

  always_ff @(posedge sclk or posedge rst) begin
    if (rst) begin
      ext_r <= '0;
      byte_tog_r <= 1'b0;
    end else begin
      ext_r <= ext_nxt;
      byte_tog_r <= byte_tog_nxt;
    end
  end

  always_ff @(posedge sclk or posedge link_rst) begin
    if (link_rst) begin
      bit_cnt_r <= '0;
      started_r <= 1'b0;
    end else begin
      bit_cnt_r <= bit_cnt_nxt;
      started_r <= started_nxt;
    end
  end

  always_ff @(negedge sclk or posedge link_rst) begin
    if (link_rst) begin
      sdo_r <= 1'b0;
      sdo_oe_r <= 1'b0;
    end else begin
      sdo_r <= sdo_nxt;
      sdo_oe_r <= sdo_oe_nxt;
    end
  end

  bit_sync #(
    .WIDTH(4)
  ) u_sync_ctl (
    .clk(clk),
    .rst(rst),
    .d({cs_n, byte_tog_r, retry_select, supply_overvoltage}),
    .q({cs_s, tog_s, retry_s, ovlo_s})
  );

  bit_sync #(
    .WIDTH(4 * `CHANNELS)
  ) u_sync_ch (
    .clk(clk),
    .rst(rst),
    .d({parallel_gate_inputs, fet_source_open, fet_source_overcurrent, fet_source_short}),
    .q({par_s, open_s, oc_s, short_s})
  );

  assign cs_rise = cs_s && !cs_q_r;
  assign cs_fall = !cs_s && cs_q_r;
  assign tog_change = tog_s != tog_q_r;
  assign deglitch_sel = cmd_r[`CMD_DEGLITCH_LSB +: `CMD_DEGLITCH_WIDTH];
  assign deglitch_limit = `TIMER_WIDTH'(DEGLITCH_BASE_CYCLES << deglitch_sel);
  assign enable = !cmd_r[`CMD_SLEEP_BIT] && !ovlo_s;

  always_comb begin
    // A byte completed in the same cycle as the frame end is still counted.
    pend_nxt = tog_change || (pend_r && !cs_rise);
    cmd_nxt = cmd_r;
    if (cs_rise && (pend_r || tog_change)) begin
      // The serial clock is idle here, so the last byte is stable.
      cmd_nxt = ext_r[FRAME_BITS-1:0];
    end
    fault_word_nxt = fault_word_r;
    if (cs_s) begin
      for (int i = 0; i < `CHANNELS; i++) begin
        fault_word_nxt[i*`CODE_WIDTH +: `CODE_WIDTH] = code_w[i];
      end
      if (ovlo_s) begin
        fault_word_nxt = `FAULT_WORD_RESET;
      end
    end
    // Latched until chip select falls; a refresh then keeps it low while a
    // channel is still held off, and a new event always wins.
    flt_nxt = cs_fall ? (|held_w) : flt_r;
    if ((|event_w) || ovlo_s) begin
      flt_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cs_q_r <= 1'b0;
      tog_q_r <= 1'b0;
      pend_r <= 1'b0;
      cmd_r <= `CMD_RESET_VALUE;
      fault_word_r <= `FAULT_WORD_RESET;
      flt_r <= 1'b0;
      flt_out_r <= 1'b0;
      sleep_r <= 1'b0;
    end else begin
      cs_q_r <= cs_s;
      tog_q_r <= tog_s;
      pend_r <= pend_nxt;
      cmd_r <= cmd_nxt;
      fault_word_r <= fault_word_nxt;
      flt_r <= flt_nxt;
      flt_out_r <= 1'b0;
      sleep_r <= cmd_r[`CMD_SLEEP_BIT];
    end
  end

  for (genvar g = 0; g < `CHANNELS; g++) begin : g_ch
    assign on_request[g] = cmd_r[`CMD_ON_LSB + g] | par_s[g];
    channel_guard u_ch (
      .clk(clk),
      .rst(rst),
      .on_request(on_request[g]),
      .enable(enable),
      .retry_select(retry_s),
      .deglitch_limit(deglitch_limit),
      .retry_off_cycles(`RETRY_WIDTH'(RETRY_OFF_CYCLES)),
      .open_det(open_s[g]),
      .overcurrent_det(oc_s[g]),
      .short_det(short_s[g]),
      .clear_code(cs_fall),
      .gate(gate_w[g]),
      .code(code_w[g]),
      .fault_event(event_w[g]),
      .held_off(held_w[g])
    );
  end

  assign gate_drive_outputs = gate_w;
  assign sdo = sdo_r;
  assign sdo_oe = sdo_oe_r;
  assign fault_interrupt_n_out = flt_out_r;
  assign fault_interrupt_n_oe = flt_r;
  assign sleep_state = sleep_r;

endmodule

// [verif/gate_fault_monitor.sv]
// Concurrent checks on the gate driver's top-level pins.
`include "gate_driver_regs.svh"
module gate_fault_monitor #(
  parameter int DEGLITCH_BASE_CYCLES = 4,
  parameter int RETRY_OFF_CYCLES = 20
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdi,
  input wire logic sdo,
  input wire logic sdo_oe,
  input wire logic retry_select,
  input wire logic [`CHANNELS-1:0] parallel_gate_inputs,
  input wire logic [`CHANNELS-1:0] fet_source_open,
  input wire logic [`CHANNELS-1:0] fet_source_overcurrent,
  input wire logic [`CHANNELS-1:0] fet_source_short,
  input wire logic supply_overvoltage,
  input wire logic [`CHANNELS-1:0] gate_drive_outputs,
  input wire logic fault_interrupt_n_in,
  input wire logic fault_interrupt_n_out,
  input wire logic fault_interrupt_n_oe,
  input wire logic sleep_state
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  chk_sdo_released: assert property (cs_n && $past(cs_n) |-> !sdo_oe)
    else $error("sdo driven with chip select high");
  chk_oe_drop_cs: assert property ($fell(sdo_oe) |-> cs_n)
    else $error("sdo released without chip select high");
  chk_oe_rise_cs: assert property ($rose(sdo_oe) |-> !cs_n)
    else $error("sdo driven outside a frame");
  chk_flt_pull_low: assert property (fault_interrupt_n_oe |-> !fault_interrupt_n_out)
    else $error("interrupt not pulled low when enabled");
  chk_sleep_gates: assert property (sleep_state |-> gate_drive_outputs == 4'h0)
    else $error("gate on during sleep");
  chk_lockout_flag: assert property (
    supply_overvoltage [*5] |-> gate_drive_outputs == 4'h0 && fault_interrupt_n_oe)
    else $error("lockout did not force gates off and interrupt on");
  chk_flt_clear_cs: assert property ($fell(fault_interrupt_n_oe) |-> !cs_n)
    else $error("interrupt cleared without chip select low");
  chk_short_latch: assert property (
    $rose(fet_source_short[0]) && gate_drive_outputs[0] && !retry_select
    |-> gate_drive_outputs[0] [*6] ##[1:600] !gate_drive_outputs[0])
    else $error("short on channel 0 not handled in time");
endmodule

// [verif/spi_host_model.sv]
// Host side of the serial link: chip select, serial clock and data out.
module spi_host_model (
  output logic sclk,
  output logic cs_n,
  output logic sdi,
  input wire logic sdo
);
  timeunit 1ns;
  timeprecision 100ps;
  // Clock idles low between frames; data idles low as its pull-down leaves it.
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi = 1'b0;
  end
  task automatic xfer(input logic [15:0] tx, input int n, output logic [15:0] rx);
    rx = 16'h0000;
    cs_n = 1'b0;
    #200;
    for (int i = n - 1; i >= 0; i--) begin
      sdi = tx[i];
      #32.5 sclk = 1'b1;
      #62.5 sclk = 1'b0;
      #30 rx = {rx[14:0], sdo};
    end
    #32.5 cs_n = 1'b1;
    sdi = 1'b0;
    #200;
  endtask
endmodule

// [verif/test_quad_gate_driver_serial_fault_ctrl.sv]
// Self-checking bench of the gate driver's link, gates and fault reporting.
`include "gate_driver_regs.svh"
module test_quad_gate_driver_serial_fault_ctrl;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int BASE = 4;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic sclk, cs_n, sdi, sdo, sdo_oe, flt_out, flt_oe, sleep_state;
  logic retry_select = 1'b0;
  logic ovl = 1'b0;
  logic [3:0] par = 4'h0, f_open = 4'h0, f_oc = 4'h0, f_short = 4'h0, gates;
  logic [15:0] rx;
  int errors = 0, cmp_count = 0, cycles = 0;
  // The interrupt net has an external pull-up.
  wire logic flt_wire = flt_oe ? flt_out : 1'b1;
  always #20 clk = ~clk;
  spi_host_model host (.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo));
  quad_gate_driver_serial_fault_ctrl #(.DEGLITCH_BASE_CYCLES(BASE), .RETRY_OFF_CYCLES(20)) dut (
    .clk(clk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe),
    .retry_select(retry_select), .parallel_gate_inputs(par), .fet_source_open(f_open),
    .fet_source_overcurrent(f_oc), .fet_source_short(f_short), .supply_overvoltage(ovl),
    .gate_drive_outputs(gates), .fault_interrupt_n_in(flt_wire),
    .fault_interrupt_n_out(flt_out), .fault_interrupt_n_oe(flt_oe), .sleep_state(sleep_state));
  task automatic close_out();
    if (errors == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic frame(input logic [7:0] cmd, input logic [7:0] exp);
    host.xfer({8'h00, cmd}, 8, rx);
    check(rx, {8'h00, exp});
    check(16'(sdo_oe), 16'h0000);
    repeat (6) @(negedge clk);
  endtask
  // Commands a channel, injects one fault kind and reads back its code.
  task automatic fault(input int ch, input int kind, input int sel, input logic [7:0] word);
    int n;
    logic [3:0] m;
    n = 0;
    m = 4'h1 << ch;
    frame({1'b0, sel[2:0], (kind == 0) ? 4'h0 : m}, 8'h00);
    @(posedge clk);
    if (kind == 0) f_open <= m;
    else if (kind == 1) f_oc <= m;
    else f_short <= m;
    while (!flt_oe && n < 700) begin
      @(negedge clk);
      n++;
    end
    check(16'(n >= (BASE << sel) && n <= (BASE << sel) + 8), 16'h0001);
    check(16'(flt_wire), 16'h0000);
    check(16'(gates[ch]), 16'h0000);
    @(posedge clk);
    f_open <= 4'h0;
    f_oc <= 4'h0;
    f_short <= 4'h0;
    repeat (40) @(negedge clk);
    check(16'(gates), (kind != 0 && retry_select) ? 16'(m) : 16'h0000);
    frame(8'h00, word);
    frame(8'h00, 8'h00);
    check(16'(flt_oe), 16'h0000);
  endtask
  // A hang is cut short well beyond the length of the sequence below.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      errors++;
      close_out();
    end
  end
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(negedge clk);
    check(16'({gates, sdo_oe, flt_oe, sleep_state}), 16'h0000);
    frame(8'h05, 8'h00);
    check(16'(gates), 16'h0005);
    @(posedge clk) par <= 4'h2;
    frame(8'h01, 8'h00);
    check(16'(gates), 16'h0003);
    frame(8'h00, 8'h00);
    check(16'(gates), 16'h0002);
    @(posedge clk) par <= 4'h0;
    repeat (6) @(negedge clk);
    check(16'(gates), 16'h0000);
    host.xfer(16'hA501, 16, rx);
    check(rx, 16'h00A5);
    repeat (6) @(negedge clk);
    check(16'(gates), 16'h0001);
    frame(8'h81, 8'h00);
    check(16'({sleep_state, gates}), 16'h0010);
    frame(8'h00, 8'h00);
    fault(0, 2, 0, 8'h03);
    @(posedge clk) retry_select <= 1'b1;
    fault(1, 1, 2, 8'h08);
    fault(3, 2, 7, 8'hC0);
    fault(2, 0, 1, 8'h10);
    @(posedge clk) ovl <= 1'b1;
    repeat (6) @(negedge clk);
    frame(8'h0F, 8'h00);
    check(16'({flt_wire, gates}), 16'h0000);
    @(posedge clk) ovl <= 1'b0;
    repeat (6) @(negedge clk);
    check(16'(gates), 16'h000F);
    frame(8'h00, 8'h00);
    check(16'(flt_oe), 16'h0000);
    close_out();
  end
endmodule
bind quad_gate_driver_serial_fault_ctrl gate_fault_monitor #(
  .DEGLITCH_BASE_CYCLES(DEGLITCH_BASE_CYCLES), .RETRY_OFF_CYCLES(RETRY_OFF_CYCLES)) mon (
  .clk(clk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe),
  .retry_select(retry_select), .parallel_gate_inputs(parallel_gate_inputs),
  .fet_source_open(fet_source_open), .fet_source_overcurrent(fet_source_overcurrent),
  .fet_source_short(fet_source_short), .supply_overvoltage(supply_overvoltage),
  .gate_drive_outputs(gate_drive_outputs), .fault_interrupt_n_in(fault_interrupt_n_in),
  .fault_interrupt_n_out(fault_interrupt_n_out), .fault_interrupt_n_oe(fault_interrupt_n_oe),
  .sleep_state(sleep_state));
